// File: design/nax_core.sv
// Nibble instruction slice: decode, execute, data memory, stack and AXI4-Lite slave.
// Assumes one clock mclk, rst_n asynchronous, wake pin asynchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module nax_core (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        wake_input_port,
  output logic             osc_stop,
  output logic [3:0]       parameter_flags,
  output logic             wdt_clk_div16384,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int STK = nax_pkg::STACK_DEPTH;

  logic [1:0]  rst_sync_r;
  logic [2:0]  wake_sync_r;
  logic        rst_core_n;
  logic        aw_ok_r, w_ok_r;
  logic [7:0]  waddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic [3:0]  nibble_result_reg;
  logic        carry_flag, zero_flag, stopped_r;
  logic [3:0]  pmf_r;
  logic [10:0] pc_r;
  logic [3:0]  sp_r;
  logic [16:0] instr_r;
  logic [6:0]  mem_addr_r;
  logic [10:0] stk_r [STK];
  logic [3:0]  dmem  [nax_pkg::DMEM_WORDS];

  nax_alu_if alu_io ();

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and wake pin synchronisers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) rst_sync_r <= 2'h0;
    else        rst_sync_r <= {rst_sync_r[0], 1'b1};
  end
  assign rst_core_n = rst_sync_r[1];

  // Stage 0 is read by stage 1 only; edge detect uses stages 1 and 2
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) wake_sync_r <= 3'h7;
    else             wake_sync_r <= {wake_sync_r[1:0], wake_input_port};
  end
  wire wake_fall = wake_sync_r[2] & ~wake_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // AXI write side: address and data taken in either order, committed together
  wire        wr_commit = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  wire [31:0] wmask     = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire        wa_instr  = (waddr_r == nax_pkg::OFF_INSTR);
  wire        wa_status = (waddr_r == nax_pkg::OFF_STATUS);
  wire        wa_pc     = (waddr_r == nax_pkg::OFF_PC);
  wire        wa_stack  = (waddr_r == nax_pkg::OFF_STACK);
  wire        wa_maddr  = (waddr_r == nax_pkg::OFF_MEM_ADDR);
  wire        wa_mdata  = (waddr_r == nax_pkg::OFF_MEM_DATA);
  wire        wa_hit    = wa_instr | wa_status | wa_pc | wa_stack | wa_maddr | wa_mdata;
  wire [31:0] ins_merge = ({15'h0000, instr_r} & ~wmask) | (wdata_r & wmask);

  assign s_axi_awready = ~aw_ok_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_ok_r & ~s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      aw_ok_r <= 1'b0;
      w_ok_r  <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_r <= 1'b1;
        waddr_r <= s_axi_awaddr;
      end else if (wr_commit) aw_ok_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_r  <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_commit) w_ok_r <= 1'b0;
    end
  end

  // Write response one cycle after the commit; unmapped offsets answer SLVERR
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= nax_pkg::RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wa_hit ? nax_pkg::RESP_OKAY : nax_pkg::RESP_SLVERR;
    end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction decode; a write to the instruction register issues it
  wire [15:0] word     = ins_merge[15:0];
  wire        imm_form = ins_merge[nax_pkg::INSTR_IMM_BIT];
  wire        exec     = wr_commit & wa_instr & ~stopped_r;       // Stopped core ignores issue
  wire [8:0]  op9      = word[15:7];
  wire [6:0]  op7      = word[15:9];
  wire [6:0]  raddr    = word[6:0];
  wire [6:0]  wr_addr  = {3'h0, word[3:0]};
  wire [3:0]  imm      = word[7:4];

  wire f_or_m  = ~imm_form & ((op9 == nax_pkg::OP9_OR)  | (op9 == nax_pkg::OP9_OR_WB));
  wire f_xor_m = ~imm_form & ((op9 == nax_pkg::OP9_XOR) | (op9 == nax_pkg::OP9_XOR_WB));
  wire f_sbc_m = ~imm_form & ((op9 == nax_pkg::OP9_SBC) | (op9 == nax_pkg::OP9_SBC_WB));
  wire f_sub_m = ~imm_form & ((op9 == nax_pkg::OP9_SUB) | (op9 == nax_pkg::OP9_SUB_WB));
  wire f_shift = ~imm_form & (op9[8:2] == nax_pkg::OP7_SHIFT);
  wire f_skb   = ~imm_form & ((op9 & nax_pkg::OP9_SKB_MSK) == {nax_pkg::OP7_SKB, 2'h0});
  wire f_or_i  = imm_form & (op7 == nax_pkg::IMM_OR);
  wire f_xor_i = imm_form & (op7 == nax_pkg::IMM_XOR);
  wire f_sbc_i = imm_form & (op7 == nax_pkg::IMM_SBC);
  wire f_sub_i = imm_form & (op7 == nax_pkg::IMM_SUB);
  wire f_rtn   = ~imm_form & (word == nax_pkg::OP_RETURN);
  wire f_setcf = ~imm_form & (word == nax_pkg::OP_SET_CF);
  wire f_stop  = ~imm_form & (word == nax_pkg::OP_STOP);
  wire f_pmf   = ~imm_form & (word[15:4] == nax_pkg::OP_PMF_PFX);

  wire f_or    = f_or_m | f_or_i;
  wire f_xor   = f_xor_m | f_xor_i;
  wire f_sbc   = f_sbc_m | f_sbc_i;
  wire f_sub   = f_sub_m | f_sub_i;
  wire alu_use = f_or | f_xor | f_sbc | f_sub | f_shift;

  // Shifts always write back; the other memory forms carry it in bit 8, immediates in word[8]
  wire       wb_en   = imm_form ? word[8] : (f_shift | op9[1]);
  wire [6:0] wb_addr = imm_form ? wr_addr : raddr;

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection toward the ALU
  wire [3:0] mem_operand = dmem[raddr];
  wire [3:0] wr_operand  = dmem[wr_addr];

  assign alu_io.op  = f_or  ? nax_pkg::ALU_OR  :
                      f_xor ? nax_pkg::ALU_XOR :
                      f_sbc ? nax_pkg::ALU_SBC :
                      f_sub ? nax_pkg::ALU_SUB :
                      !f_shift ? nax_pkg::ALU_PASS :
                      (op9[1:0] == 2'h0) ? nax_pkg::ALU_SHL :
                      (op9[1:0] == 2'h1) ? nax_pkg::ALU_RLC :
                      (op9[1:0] == 2'h2) ? nax_pkg::ALU_SHR :
                      nax_pkg::ALU_RRC;
  assign alu_io.a   = imm_form ? wr_operand : mem_operand;
  assign alu_io.b   = imm_form ? imm : nibble_result_reg;
  assign alu_io.cin = carry_flag;

  nax_alu u_alu (
    .io (alu_io)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Program counter next value: return, skip or plain step
  wire [1:0]  skb_sel  = {op9[2], op9[0]};
  wire        skip_hit = f_skb & mem_operand[skb_sel];
  wire [3:0]  sp_dec   = sp_r - 4'h1;
  wire [10:0] rtn_pc   = (sp_r == 4'h0) ? nax_pkg::PC_RST : stk_r[sp_dec[2:0]];
  wire [10:0] pc_step  = pc_r + (skip_hit ? 11'h002 : 11'h001);
  wire [10:0] pc_nxt   = f_rtn ? rtn_pc : pc_step;

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)              pc_r <= nax_pkg::PC_RST;
    else if (exec)                pc_r <= pc_nxt;
    else if (wr_commit && wa_pc)  pc_r <= (wdata_r[10:0] & wmask[10:0]) | (pc_r & ~wmask[10:0]);
  end

  // Return stack: pushes by software, pops by the return instruction
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)                                           sp_r <= 4'h0;
    else if (exec && f_rtn && sp_r != 4'h0)                    sp_r <= sp_dec;
    else if (wr_commit && wa_stack && sp_r < 4'(STK))          sp_r <= sp_r + 4'h1;
  end
  always_ff @(posedge mclk) begin
    if (wr_commit && wa_stack && sp_r < 4'(STK)) stk_r[sp_r[2:0]] <= wdata_r[10:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result register and flags
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      nibble_result_reg <= nax_pkg::ACC_RST;
      zero_flag         <= 1'b0;
    end else if (exec && alu_use) begin
      nibble_result_reg <= alu_io.res;
      zero_flag         <= alu_io.zout;
    end
  end

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)                            carry_flag <= 1'b0;
    else if (exec && f_setcf)                   carry_flag <= 1'b1;
    else if (exec && alu_use && alu_io.cf_upd)  carry_flag <= alu_io.cout;
  end

  // Only bit 3 has a function; bits 0 to 2 are kept but steer nothing
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)          pmf_r <= nax_pkg::PMF_RST;
    else if (exec && f_pmf)   pmf_r <= word[3:0];
  end
  assign parameter_flags  = pmf_r;
  assign wdt_clk_div16384 = pmf_r[nax_pkg::PMF_WDT_BIT];

  // Stop: the wake edge wins over a stop issued in the same cycle
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)           stopped_r <= 1'b0;
    else if (wake_fall)        stopped_r <= 1'b0;
    else if (exec && f_stop)   stopped_r <= 1'b1;
  end
  assign osc_stop = stopped_r;

  // Last instruction word written, issued or not, kept for read-back
  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)               instr_r <= nax_pkg::INS_RST;
    else if (wr_commit && wa_instr) instr_r <= ins_merge[16:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory: one write port shared by writeback and software
  wire       mem_we = (exec & alu_use & wb_en) | (wr_commit & wa_mdata & wstrb_r[0]);
  wire [6:0] mem_wa = exec ? wb_addr : mem_addr_r;
  wire [3:0] mem_wd = exec ? alu_io.res : wdata_r[3:0];

  always_ff @(posedge mclk) begin
    if (mem_we) dmem[mem_wa] <= mem_wd;
  end

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n)                          mem_addr_r <= 7'h00;
    else if (wr_commit && wa_maddr && wstrb_r[0]) mem_addr_r <= wdata_r[6:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI read side: one cycle to answer, data held until taken
  wire [31:0] status_word = {16'h0000, sp_r, pmf_r, 1'b0, stopped_r, zero_flag, carry_flag,
                             nibble_result_reg};
  wire [31:0] rd_mux =
    (s_axi_araddr == nax_pkg::OFF_INSTR)    ? {15'h0000, instr_r} :
    (s_axi_araddr == nax_pkg::OFF_STATUS)   ? status_word :
    (s_axi_araddr == nax_pkg::OFF_PC)       ? {21'h000000, pc_r} :
    (s_axi_araddr == nax_pkg::OFF_STACK)    ? {28'h0000000, sp_r} :
    (s_axi_araddr == nax_pkg::OFF_MEM_ADDR) ? {25'h0000000, mem_addr_r} :
    (s_axi_araddr == nax_pkg::OFF_MEM_DATA) ? {28'h0000000, dmem[mem_addr_r]} : 32'h0000_0000;
  wire rd_hit = (s_axi_araddr == nax_pkg::OFF_INSTR) | (s_axi_araddr == nax_pkg::OFF_STATUS) |
                (s_axi_araddr == nax_pkg::OFF_PC) | (s_axi_araddr == nax_pkg::OFF_STACK) |
                (s_axi_araddr == nax_pkg::OFF_MEM_ADDR) | (s_axi_araddr == nax_pkg::OFF_MEM_DATA);

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge mclk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= nax_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? nax_pkg::RESP_OKAY : nax_pkg::RESP_SLVERR;
    end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
  end

endmodule // nax_core
`default_nettype wire

// File: inc/nax_pkg.sv
// Constants, opcodes and register map of the nibble ALU instruction slice.
// Assumes a 40 MHz core clock and an AXI4-Lite master with 32-bit data.
package nax_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_INSTR    = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_PC       = 8'h08;
  localparam logic [7:0]  OFF_STACK    = 8'h0C;
  localparam logic [7:0]  OFF_MEM_ADDR = 8'h10;
  localparam logic [7:0]  OFF_MEM_DATA = 8'h14;

  // Field positions
  localparam int INSTR_IMM_BIT  = 16;
  localparam int ST_CF_BIT      = 4;
  localparam int ST_ZF_BIT      = 5;
  localparam int ST_STOP_BIT    = 6;
  localparam int ST_PMF_LSB     = 8;
  localparam int ST_SP_LSB      = 12;
  localparam int PMF_WDT_BIT    = 3;

  // Reset values
  localparam logic [10:0] PC_RST  = 11'h000;
  localparam logic [3:0]  ACC_RST = 4'h0;
  localparam logic [3:0]  PMF_RST = 4'h0;
  localparam logic [16:0] INS_RST = 17'h00000;

  // Sizes
  localparam int          STACK_DEPTH = 8;
  localparam int          DMEM_WORDS  = 128;
  localparam int          WDT_DIV     = 16384;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Memory forms: word[15:7]
  localparam logic [8:0]  OP9_OR      = 9'h074;
  localparam logic [8:0]  OP9_OR_WB   = 9'h076;
  localparam logic [8:0]  OP9_XOR     = 9'h070;
  localparam logic [8:0]  OP9_XOR_WB  = 9'h072;
  localparam logic [8:0]  OP9_SBC     = 9'h014;
  localparam logic [8:0]  OP9_SBC_WB  = 9'h016;
  localparam logic [8:0]  OP9_SUB     = 9'h034;
  localparam logic [8:0]  OP9_SUB_WB  = 9'h036;
  localparam logic [6:0]  OP7_SHIFT   = 7'h26;
  localparam logic [6:0]  OP7_SKB     = 7'h44;
  localparam logic [8:0]  OP9_SKB_MSK = 9'h1FA;
  // Immediate forms: word[15:9], word[8] writeback
  localparam logic [6:0]  IMM_SBC     = 7'h07;
  localparam logic [6:0]  IMM_SUB     = 7'h0F;
  localparam logic [6:0]  IMM_OR      = 7'h1E;
  localparam logic [6:0]  IMM_XOR     = 7'h1C;
  // Whole-word forms; the flag-load form matches word[15:4] only
  localparam logic [15:0] OP_RETURN   = 16'h0080;
  localparam logic [15:0] OP_SET_CF   = 16'h2800;
  localparam logic [15:0] OP_STOP     = 16'h0060;
  localparam logic [11:0] OP_PMF_PFX  = 12'h016;

  typedef enum logic [3:0] {
    ALU_PASS, ALU_OR, ALU_XOR, ALU_SUB, ALU_SBC,
    ALU_RLC, ALU_RRC, ALU_SHL, ALU_SHR
  } nax_alu_op_e;

endpackage

// File: inc/nax_alu_if.sv
// Operand and result bundle between the core sequencer and the nibble ALU.
// Assumes both ends sit in the same clock domain; the path is combinational.
`timescale 1ns/1ps
`default_nettype none
interface nax_alu_if;
  nax_pkg::nax_alu_op_e op;
  logic [3:0]           a;
  logic [3:0]           b;
  logic                 cin;
  logic [3:0]           res;
  logic                 cout;
  logic                 cf_upd;
  logic                 zout;

  modport core (output op, output a, output b, output cin,
                input res, input cout, input cf_upd, input zout);
  modport alu  (input op, input a, input b, input cin,
                output res, output cout, output cf_upd, output zout);
endinterface
`default_nettype wire

// File: design/nax_alu.sv
// Combinational nibble ALU: logic ops, subtracts and carry shifts.
// Assumes the core registers every result it takes from here.
`timescale 1ns/1ps
`default_nettype none
module nax_alu (
  nax_alu_if.alu io
);
  logic [4:0] diff;

  ////////////////////////////////////////////////////////////////////////////
  // Result and carry per operation
  always_comb begin
    diff      = 5'h00;
    io.res    = io.a;
    io.cout   = io.cin;
    io.cf_upd = 1'b0;
    case (io.op)
      nax_pkg::ALU_OR:  io.res = io.a | io.b;
      nax_pkg::ALU_XOR: io.res = io.a ^ io.b;
      nax_pkg::ALU_SUB: begin
        diff      = {1'b0, io.a} - {1'b0, io.b};
        io.res    = diff[3:0];
        io.cout   = ~diff[4];
        io.cf_upd = 1'b1;
      end
      nax_pkg::ALU_SBC: begin
        diff      = {1'b0, io.a} - {1'b0, io.b} - {4'h0, io.cin};
        io.res    = diff[3:0];
        io.cout   = ~diff[4];
        io.cf_upd = 1'b1;
      end
      nax_pkg::ALU_RLC: begin
        io.res    = {io.a[2:0], io.cin};
        io.cout   = io.a[3];
        io.cf_upd = 1'b1;
      end
      nax_pkg::ALU_RRC: begin
        io.res    = {io.cin, io.a[3:1]};
        io.cout   = io.a[0];
        io.cf_upd = 1'b1;
      end
      nax_pkg::ALU_SHL: begin
        io.res    = {io.a[2:0], 1'b0};
        io.cout   = io.a[3];
        io.cf_upd = 1'b1;
      end
      nax_pkg::ALU_SHR: begin
        io.res    = {1'b0, io.a[3:1]};
        io.cout   = io.a[0];
        io.cf_upd = 1'b1;
      end
      default: io.res = io.a;
    endcase
  end

  // Zero flag follows the 4-bit result only
  assign io.zout = (io.res == 4'h0);
endmodule // nax_alu
`default_nettype wire

// File: tb/nax_monitor.sv
// Checker for the nibble slice, watching the top ports only.
// Assumes one clock domain; idle while rst_n is low.
`timescale 1ns/1ps
`default_nettype none
module nax_monitor (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        wake_input_port,
  input wire logic        osc_stop,
  input wire logic [3:0]  parameter_flags,
  input wire logic        wdt_clk_div16384,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Steps: both write channels taken; wake edge seen while stopped
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_wake_fall;
    osc_stop && $fell(wake_input_port);
  endsequence
  a_write_answer: assert property (s_write_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_wdt_follows_flag: assert property (wdt_clk_div16384 == parameter_flags[3])
    else $error("watchdog clock select differs from flag");
  a_flags_need_write: assert property ($changed(parameter_flags) |-> $rose(s_axi_bvalid))
    else $error("flags changed without a write");
  a_wake_resumes: assert property (s_wake_fall |-> ##[1:5] !osc_stop)
    else $error("no wake after falling edge");
  a_stop_holds: assert property ((osc_stop && wake_input_port) [*4] |=> osc_stop)
    else $error("left stop without wake edge");
endmodule // nax_monitor
bind nax_core nax_monitor u_nax_monitor (.mclk(mclk), .rst_n(rst_n),
  .wake_input_port(wake_input_port), .osc_stop(osc_stop), .parameter_flags(parameter_flags),
  .wdt_clk_div16384(wdt_clk_div16384), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
`default_nettype wire

// File: tb/nax_core_tb.sv
// Self-checking bench for the nibble instruction slice.
// Drives nax_core over AXI4-Lite and the wake pin; strobes tied full.
`timescale 1ns/1ps
`default_nettype none
module nax_core_tb;
  logic        mclk = 0, rst_n = 0, wake = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
  logic        osc_stop, wdt, cf, zf;
  logic [7:0]  awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  pflags, acc, v, imm, mexp;
  logic [4:0]  r5;
  logic [6:0]  ad;
  logic [10:0] p;
  logic [16:0] word;
  int          miscompares = 0, checks = 0, cyc = 0, op, kind, seed = 32'h062fcf72;
  localparam logic [8:0] P9 [8] = '{9'h074, 9'h076, 9'h070, 9'h072, 9'h014, 9'h016, 9'h034, 9'h036};
  localparam logic [6:0] C7 [4] = '{7'h1E, 7'h1C, 7'h07, 7'h0F};
  always #12.5 mclk = ~mclk;
  nax_core u_nax_core (.mclk(mclk), .rst_n(rst_n), .wake_input_port(wake), .osc_stop(osc_stop),
    .parameter_flags(pflags), .wdt_clk_div16384(wdt), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Ready is read mid-cycle, where it equals its value at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] x, output logic [1:0] r);
    logic aw, w, g;
    awaddr <= a;
    wdata <= x;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(negedge mclk);
      aw = awvalid & awready;
      w = wvalid & wready;
      g = bvalid & bready;
      r = bresp;
      @(posedge mclk);
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
      if (!bready) bready <= 1'($random(seed)); // Random stalls on the response
    end while (!g);
    bready <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic [1:0] r);
    logic ar, g;
    araddr <= a;
    arvalid <= 1;
    do begin
      @(negedge mclk);
      ar = arvalid & arready;
      g = rvalid & rready;
      q = rdata;
      r = rresp;
      @(posedge mclk);
      if (ar) arvalid <= 0;
      if (!rready) rready <= 1'($random(seed));
    end while (!g);
    rready <= 0;
    @(posedge mclk);
  endtask
  task automatic exec(input logic [16:0] w);
    wr(nax_pkg::OFF_INSTR, {15'h0, w}, rsp);
  endtask
  // Expected {carry, result}; subtract carry is one when no borrow
  function automatic logic [4:0] alu(input int k, input logic [3:0] a, y, input logic c);
    case (k)
      0: return {c, a | y};
      1: return {c, a ^ y};
      2: return {1'b1, a} - {1'b0, y} - 5'(c);
      3: return {1'b1, a} - {1'b0, y};
      4: return {a[3], a[2:0], 1'b0};
      5: return {a[3], a[2:0], c};
      6: return {a[0], 1'b0, a[3:1]};
      default: return {a[0], c, a[3:1]};
    endcase
  endfunction
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    repeat (3) @(posedge mclk);
    // Set carry first so the model starts from known flags
    acc = nax_pkg::ACC_RST;
    cf = 1;
    wr(nax_pkg::OFF_PC, 32'h123, rsp);
    exec(17'h02800);
    rd(nax_pkg::OFF_PC, d, rsp);
    check(d[10:0], 11'h124);
    rd(nax_pkg::OFF_STATUS, d, rsp);
    check(d[4:0], {cf, acc});
    // Every ALU form once, then random ones
    for (int i = 0; i < 60; i++) begin
      op = (i < 20) ? i : {$random(seed)} % 20;
      v = 4'($random(seed));
      imm = 4'($random(seed));
      ad = (op < 12) ? 7'($random(seed)) : {3'h0, 4'($random(seed))};
      kind = (op < 8) ? op / 2 : (op < 12) ? op - 4 : (op - 12) / 2;
      if (op < 8) word = {1'b0, P9[op], ad};
      else if (op < 12) word = {1'b0, 9'(9'h098 + op - 8), ad};
      else word = {1'b1, C7[kind], 1'(op), imm, ad[3:0]};
      r5 = alu(kind, v, (op < 12) ? acc : imm, cf);
      mexp = (op % 2 == 1 || (op >= 8 && op < 12)) ? r5[3:0] : v;
      wr(nax_pkg::OFF_MEM_ADDR, {25'h0, ad}, rsp);
      wr(nax_pkg::OFF_MEM_DATA, {28'h0, v}, rsp);
      exec(word);
      {cf, acc} = r5;
      zf = (acc == 4'h0);
      rd(nax_pkg::OFF_STATUS, d, rsp);
      check(d[5:0], {zf, cf, acc});
      rd(nax_pkg::OFF_MEM_DATA, d, rsp);
      check(d[3:0], mexp);
    end
    // Bit tests: each bit set, then each bit clear
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? 4'h1 << i[1:0] : ~(4'h1 << i[1:0]);
      p = 11'($random(seed));
      wr(nax_pkg::OFF_MEM_DATA, {28'h0, v}, rsp);
      wr(nax_pkg::OFF_PC, {21'h0, p}, rsp);
      exec({1'b0, 9'h110 | {6'h0, i[1], 1'b0, i[0]}, ad});
      rd(nax_pkg::OFF_PC, d, rsp);
      check(d[10:0], p + 11'd1 + 11'(v[i[1:0]]));
    end
    p = 11'($random(seed));
    wr(nax_pkg::OFF_STACK, {21'h0, p}, rsp);
    exec(17'h00080);
    rd(nax_pkg::OFF_PC, d, rsp);
    check(d[10:0], p);
    for (int i = 0; i < 4; i++) begin
      imm = (i == 0) ? 4'h8 : (i == 1) ? 4'h7 : 4'($random(seed));
      exec({1'b0, 12'h016, imm});
      check(pflags, imm);
      check(wdt, imm[3]);
    end
    // Stop, ignore an instruction, then wake on a falling edge
    exec(17'h00060);
    rd(nax_pkg::OFF_PC, d, rsp);
    p = d[10:0];
    check(osc_stop, 1'b1);
    exec({1'b0, 12'h016, ~imm});
    check(pflags, imm);
    wake <= 0;
    for (int n = 0; n < 8 && osc_stop; n++) @(posedge mclk);
    @(negedge mclk);
    check(osc_stop, 1'b0);
    @(posedge mclk);
    wake <= 1;
    exec(17'h02800);
    rd(nax_pkg::OFF_PC, d, rsp);
    check(d[10:0], p + 11'd1);
    wr(8'h18, 32'h5, rsp);
    check(rsp, nax_pkg::RESP_SLVERR);
    rd(8'h18, d, rsp);
    check(rsp, nax_pkg::RESP_SLVERR);
    check(d, 32'h0000_0000);
    conclude();
  end
endmodule // nax_core_tb
`default_nettype wire
